// *** rtl/step_arbiter.sv ***
// Purpose: first-to-switch arbiter of the two comparators
// Assumes: comparator outputs are synchronous to clk and low once crossed
// Notes: a tie in the decision cycle gives no step at all
`timescale 1ns/1ps

module step_arbiter
  import touch_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic decide,
  input wire logic ref_cmp_n,
  input wire logic in_cmp_n,
  step_bus_if.arb steps
);

  logic up_q;
  logic up_d;
  logic down_q;
  logic down_d;

  // reference low alone means the plate discharges slower
  assign up_d = decide & ~ref_cmp_n & in_cmp_n;
  assign down_d = decide & ~in_cmp_n & ref_cmp_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 1'b0;
      down_q <= 1'b0;
    end else begin
      up_q <= up_d;
      down_q <= down_d;
    end
  end

  assign steps.up_step_pulse = up_q;
  assign steps.down_step_pulse = down_q;

endmodule

// *** rtl/step_bus_if.sv ***
// Purpose: carries step pulses from the arbiter to the decision logic
// Assumes: one clock domain
// Notes: pulses are one clk cycle wide, never both at once
`timescale 1ns/1ps

interface step_bus_if;
  logic up_step_pulse;
  logic down_step_pulse;
  modport arb (output up_step_pulse, output down_step_pulse);
  modport dec (input up_step_pulse, input down_step_pulse);
endinterface

// *** rtl/touch_cfg.svh ***
// Purpose: timing and encoding constants of the touch decision logic
// Assumes: clk is the timing-circuit oscillator at 100 MHz (10 ns)
// Notes: definitions only
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// oscillator rate and division down to the sampling rate
`define TOUCH_CLK_MHZ 100
`define TOUCH_SAMPLE_DIV 2
// consecutive same-direction steps that make a capacitive event
`define TOUCH_RUN_THRESHOLD 8
`define TOUCH_RUN_W 8
// duration of one calibration charge or sink step, in ns; one sampling
// period at most, so a following step never cuts it short
`define TOUCH_STEP_NS 20
`define TOUCH_STEP_CYCLES ((`TOUCH_STEP_NS * `TOUCH_CLK_MHZ) / 1000)
// pulse mode: 2.5 ms per nF of mode capacitor, 4.7 nF typical
`define TOUCH_PULSE_US_PER_NF 2500
`define TOUCH_TYPE_CAP_PF 4700
`define TOUCH_PULSE_US ((`TOUCH_PULSE_US_PER_NF * `TOUCH_TYPE_CAP_PF) / 1000)
`define TOUCH_PULSE_SAMPLES (`TOUCH_PULSE_US * `TOUCH_CLK_MHZ / `TOUCH_SAMPLE_DIV)
// pseudo-random frequency modulation
`define TOUCH_SPREAD_PCT 4
`define TOUCH_LFSR_W 8
`define TOUCH_LFSR_SEED 8'h5a
`define TOUCH_LFSR_TAPS 8'hb8
`define TOUCH_TRIM_W 4
// mode select encodings
`define TOUCH_MODE_PUSH 2'b00
`define TOUCH_MODE_TOGGLE 2'b01
`define TOUCH_MODE_PULSE 2'b11

`endif

// *** rtl/touch_decision.sv ***
// Purpose: decision logic of a capacitive touch and proximity switch
// Assumes: clk is the modulated timing oscillator; all inputs synchronous
// Notes: analog charge, sink and driver electrics sit outside this block
// Function
// - both timing circuits charged by one signal
// - first comparator low picks up or down
// - each step drives calibration node fixed time
// - count consecutive same-direction steps
// - direction change clears the run counter
// - event only after enough consecutive steps
// - alternating steps keep counter near zero
// - sampling rate is oscillator divided by two
// - pseudo-random oscillator modulation, four percent spread
// - overcurrent forces switch output inactive
// - toggle inverts output per new event
// - pulse mode gives timed output per event
// - pulse mode ignores events while active
`timescale 1ns/1ps
`include "touch_cfg.svh"

module touch_decision
  import touch_pkg::*;
#(
  parameter int unsigned RUN_THRESHOLD = `TOUCH_RUN_THRESHOLD,
  parameter int unsigned STEP_CYCLES = `TOUCH_STEP_CYCLES,
  parameter int unsigned PULSE_SAMPLES = `TOUCH_PULSE_SAMPLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ref_cmp_n,
  input wire logic in_cmp_n,
  input wire logic [1:0] output_mode_select,
  input wire logic overcurrent,
  output logic charge_ctrl,
  output logic up_step_pulse,
  output logic down_step_pulse,
  output logic cal_supply_en,
  output logic cal_sink_en,
  output logic [`TOUCH_TRIM_W-1:0] osc_trim,
  output logic capacitive_event,
  output logic switch_output,
  output logic switch_output_oe_n
);

  localparam int unsigned STEP_W = $clog2(STEP_CYCLES + 1);
  localparam int unsigned PULSE_W = $clog2(PULSE_SAMPLES + 1);
  localparam logic [STEP_W-1:0] STEP_LEN = STEP_W'(STEP_CYCLES);
  localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(PULSE_SAMPLES);
  localparam logic [`TOUCH_RUN_W-1:0] RUN_LIMIT = `TOUCH_RUN_W'(RUN_THRESHOLD);
  localparam logic [`TOUCH_RUN_W-1:0] RUN_MAX = {`TOUCH_RUN_W{1'b1}};
  localparam logic [`TOUCH_RUN_W-1:0] RUN_ONE = `TOUCH_RUN_W'(1);

  function automatic out_mode_t decode_mode(input logic [1:0] code);
    out_mode_t m;
    m = MODE_PUSH;
    if (code == `TOUCH_MODE_TOGGLE) begin
      m = MODE_TOGGLE;
    end else if (code == `TOUCH_MODE_PULSE) begin
      m = MODE_PULSE;
    end
    return m;
  endfunction

  // sampling phase: charge one period, discharge the next
  phase_t phase_q;
  phase_t phase_d;
  logic decide;

  assign phase_d = (phase_q == PHASE_CHARGE) ? PHASE_DISCHARGE : PHASE_CHARGE;
  assign decide = (phase_q == PHASE_DISCHARGE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= PHASE_CHARGE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // a single registered signal drives both switches so they never skew
  logic charge_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_q <= 1'b0;
    end else begin
      charge_q <= (phase_d == PHASE_CHARGE);
    end
  end
  assign charge_ctrl = charge_q;

  // arbiter
  step_bus_if steps ();
  step_arbiter u_arbiter (
    .clk(clk),
    .reset_n(reset_n),
    .decide(decide),
    .ref_cmp_n(ref_cmp_n),
    .in_cmp_n(in_cmp_n),
    .steps(steps)
  );
  assign up_step_pulse = steps.up_step_pulse;
  assign down_step_pulse = steps.down_step_pulse;

  // calibration node drive, fixed length per step
  logic [STEP_W-1:0] step_cnt_q;
  logic [STEP_W-1:0] step_cnt_d;
  step_dir_t step_dir_q;
  logic any_step;

  assign any_step = steps.up_step_pulse | steps.down_step_pulse;
  assign step_cnt_d = any_step ? STEP_LEN
                    : (step_cnt_q != '0) ? step_cnt_q - STEP_W'(1) : step_cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_q <= '0;
      step_dir_q <= DIR_UP;
    end else begin
      step_cnt_q <= step_cnt_d;
      if (any_step) begin
        step_dir_q <= steps.down_step_pulse ? DIR_DOWN : DIR_UP;
      end
    end
  end

  assign cal_supply_en = (step_cnt_q != '0) && (step_dir_q == DIR_UP);
  assign cal_sink_en = (step_cnt_q != '0) && (step_dir_q == DIR_DOWN);

  // run-length counter
  logic [`TOUCH_RUN_W-1:0] run_q;
  logic [`TOUCH_RUN_W-1:0] run_d;
  step_dir_t run_dir_q;
  step_dir_t new_dir;
  logic same_dir;

  assign new_dir = steps.down_step_pulse ? DIR_DOWN : DIR_UP;
  assign same_dir = (new_dir == run_dir_q) && (run_q != '0);

  // cleared on a change, and the step that changed it counts as the first
  always_comb begin
    run_d = run_q;
    if (any_step) begin
      if (same_dir) begin
        run_d = (run_q == RUN_MAX) ? run_q : run_q + RUN_ONE;
      end else begin
        run_d = RUN_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= '0;
      run_dir_q <= DIR_UP;
    end else begin
      run_q <= run_d;
      if (any_step) begin
        run_dir_q <= new_dir;
      end
    end
  end

  // event holds from threshold until the direction turns
  logic event_now;
  logic event_q;
  logic event_rise;

  assign event_now = (run_q >= RUN_LIMIT);
  assign event_rise = event_now & ~event_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_now;
    end
  end
  assign capacitive_event = event_q;

  // pseudo-random oscillator trim, stepped once per sample
  logic [`TOUCH_LFSR_W-1:0] lfsr_q;
  logic [`TOUCH_LFSR_W-1:0] lfsr_d;
  logic lfsr_fb;

  assign lfsr_fb = ^(lfsr_q & `TOUCH_LFSR_TAPS);
  assign lfsr_d = {lfsr_q[`TOUCH_LFSR_W-2:0], lfsr_fb};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_q <= `TOUCH_LFSR_SEED;
    end else if (decide) begin
      lfsr_q <= lfsr_d;
    end
  end
  // full-scale code spans the whole spread; the oscillator scales it
  assign osc_trim = lfsr_q[`TOUCH_TRIM_W-1:0];

  // output modes
  out_mode_t mode;
  pulse_state_t pstate_q;
  pulse_state_t pstate_d;
  logic [PULSE_W-1:0] pcnt_q;
  logic [PULSE_W-1:0] pcnt_d;
  logic toggle_q;
  logic out_d;
  logic out_q;

  assign mode = decode_mode(output_mode_select);

  always_comb begin
    pstate_d = pstate_q;
    pcnt_d = pcnt_q;
    unique case (pstate_q)
      PULSE_IDLE: begin
        if (mode == MODE_PULSE && event_rise) begin
          pstate_d = PULSE_ON;
          pcnt_d = PULSE_LEN;
        end
      end
      PULSE_ON: begin
        // further events ignored here
        if (decide) begin
          if (pcnt_q <= PULSE_W'(1)) begin
            pstate_d = PULSE_IDLE;
            pcnt_d = '0;
          end else begin
            pcnt_d = pcnt_q - PULSE_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pstate_q <= PULSE_IDLE;
      pcnt_q <= '0;
    end else begin
      pstate_q <= pstate_d;
      pcnt_q <= pcnt_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_q <= 1'b0;
    end else if (mode == MODE_TOGGLE && event_rise) begin
      toggle_q <= ~toggle_q;
    end
  end

  always_comb begin
    unique case (mode)
      MODE_PUSH: out_d = event_now;
      MODE_TOGGLE: out_d = toggle_q;
      MODE_PULSE: out_d = (pstate_d == PULSE_ON);
    endcase
    // short-circuit protection overrides every mode
    if (overcurrent) begin
      out_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // open-drain high side: drive only while active
  assign switch_output = out_q;
  assign switch_output_oe_n = ~out_q;

endmodule

// *** rtl/touch_pkg.sv ***
// Purpose: shared types of the touch decision logic
// Assumes: touch_cfg.svh holds the numeric constants
// Notes: mode code 2'b10 is illegal and treated as push-button
`include "touch_cfg.svh"

package touch_pkg;

  typedef enum logic [1:0] {
    MODE_PUSH = `TOUCH_MODE_PUSH,
    MODE_TOGGLE = `TOUCH_MODE_TOGGLE,
    MODE_PULSE = `TOUCH_MODE_PULSE
  } out_mode_t;

  typedef enum logic {
    PHASE_CHARGE = 1'b0,
    PHASE_DISCHARGE = 1'b1
  } phase_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_ON = 2'b01
  } pulse_state_t;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } step_dir_t;

endpackage

// *** tb/cmp_model.sv ***
// Purpose: comparator pair in front of the decision logic
// Assumes: cmd 0 reference first, 1 plate first, 2 and 3 ties
// Notes: levels hold per command, so either edge of a phase sees them
`timescale 1ns/1ps
module cmp_model (
  input wire logic [1:0] cmd,
  output logic ref_cmp_n,
  output logic in_cmp_n
);
  // code 3 drops both at once, the harder tie
  assign ref_cmp_n = !(cmd == 2'h0 || cmd == 2'h3);
  assign in_cmp_n = !(cmd == 2'h1 || cmd == 2'h3);
endmodule

// *** tb/tb_capacitive_touch_decision_logic.sv ***
// Purpose: self-checking bench of the touch decision logic
// Assumes: pulse mode shortened to 16 samples
// Notes: each step noted in a queue, popped when a pulse shows
`timescale 1ns/1ps
`include "touch_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_capacitive_touch_decision_logic
  import touch_pkg::*;
;
  logic clk, reset_n, overcurrent, ref_cmp_n, in_cmp_n, charge_ctrl, ok_q;
  logic up_step_pulse, down_step_pulse, cal_supply_en, cal_sink_en;
  logic capacitive_event, switch_output, switch_output_oe_n;
  logic [1:0] output_mode_select, cmd;
  logic [`TOUCH_TRIM_W-1:0] osc_trim;
  logic [31:0] lfsr_q;
  int fails, compares, hi_cnt, ev_cnt;
  step_dir_t e_d;
  step_dir_t exp_q[$];
  localparam int PULSE_S = 16;
  touch_decision #(.PULSE_SAMPLES(PULSE_S)) DUT (
    .clk(clk), .reset_n(reset_n), .ref_cmp_n(ref_cmp_n), .in_cmp_n(in_cmp_n),
    .output_mode_select(output_mode_select), .overcurrent(overcurrent),
    .charge_ctrl(charge_ctrl), .up_step_pulse(up_step_pulse),
    .down_step_pulse(down_step_pulse), .cal_supply_en(cal_supply_en),
    .cal_sink_en(cal_sink_en), .osc_trim(osc_trim), .capacitive_event(capacitive_event),
    .switch_output(switch_output), .switch_output_oe_n(switch_output_oe_n)
  );
  cmp_model u_cmp (.cmd(cmd), .ref_cmp_n(ref_cmp_n), .in_cmp_n(in_cmp_n));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one step per charge phase; a tie afterwards stops further steps
  task automatic run(input logic [1:0] c, input int n);
    int k;
    for (int i = 0; i <= n; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (charge_ctrl !== 1'b1 && k < 4);
      if (k >= 4) begin
        fails++;
        tally_and_finish();
      end
      cmd = (i == n) ? 2'h2 : c;
      if (i < n && c < 2'h2) exp_q.push_back(step_dir_t'(c[0]));
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  always @(negedge clk) begin
    if (switch_output === 1'b1) hi_cnt++;
    if (capacitive_event === 1'b1) ev_cnt++;
    if (up_step_pulse === 1'b1 || down_step_pulse === 1'b1) begin
      ok_q = exp_q.size() != 0;
      `CHK("step expected", 1'b1, ok_q)
      if (ok_q) begin
        e_d = exp_q.pop_front();
        `CHK("step dir", e_d, down_step_pulse)
      end
    end
  end
  initial begin
    reset_n = 0;
    overcurrent = 0;
    output_mode_select = 2'h0;
    cmd = 2'h2;
    lfsr_q = 32'ha5fe993a;
    repeat (10) @(posedge clk);
    #1 reset_n = 1;
    `CHK("oe_n", 1'b1, switch_output_oe_n)
    `CHK("trim", 4'ha, osc_trim)
    for (int t = 2; t < 4; t++) run(2'(t), 3);
    $display("test reset and ties done");
    ev_cnt = 0;
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      run(2'(i % 2), int'(lfsr_q[2:0] % 3'h7) + 1);
    end
    idle(4);
    `CHK("alternating events", 0, ev_cnt)
    $display("test alternating done");
    run(2'h0, 10);
    `CHK("supply on", 1'b1, cal_supply_en)
    idle(4);
    `CHK("supply off", 1'b0, cal_supply_en)
    `CHK("event", 1'b1, capacitive_event)
    `CHK("push on", 1'b1, switch_output)
    overcurrent = 1;
    idle(3);
    `CHK("overcurrent off", 1'b0, switch_output)
    overcurrent = 0;
    output_mode_select = 2'h2;
    idle(3);
    `CHK("push back on", 1'b1, switch_output)
    run(2'h1, 1);
    idle(1);
    `CHK("sink on", 1'b1, cal_sink_en)
    idle(3);
    `CHK("sink off", 1'b0, cal_sink_en)
    `CHK("event cleared", 1'b0, capacitive_event)
    `CHK("push off", 1'b0, switch_output)
    $display("test push done");
    output_mode_select = 2'h1;
    run(2'h1, 9);
    idle(4);
    `CHK("toggle on", 1'b1, switch_output)
    run(2'h0, 9);
    idle(4);
    `CHK("toggle off", 1'b0, switch_output)
    $display("test toggle done");
    output_mode_select = 2'h3;
    hi_cnt = 0;
    // a second event rises while the output is still on and must not restart it
    run(2'h1, 8);
    run(2'h0, 1);
    run(2'h1, 8);
    `CHK("pulse held", 1'b1, switch_output)
    idle(14);
    `CHK("pulse length", 2 * PULSE_S, hi_cnt)
    `CHK("event held", 1'b1, capacitive_event)
    `CHK("pulse over", 1'b0, switch_output)
    $display("test pulse done");
    `CHK("steps missing", 0, exp_q.size())
    tally_and_finish();
  end
endmodule

// *** tb/touch_decision_sva.sv ***
// Purpose: port checks of touch_decision
// Assumes: default step length of 2 cycles
// Notes: bound into every touch_decision
`timescale 1ns/1ps
module touch_decision_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] output_mode_select,
  input wire logic overcurrent,
  input wire logic charge_ctrl,
  input wire logic up_step_pulse,
  input wire logic down_step_pulse,
  input wire logic cal_supply_en,
  input wire logic cal_sink_en,
  input wire logic capacitive_event,
  input wire logic switch_output,
  input wire logic switch_output_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_one_dir; !(up_step_pulse && down_step_pulse); endproperty
  a_one_dir: assert property (p_one_dir) else $error("both step pulses high");
  property p_up_cal; up_step_pulse |=> cal_supply_en [*2]; endproperty
  a_up_cal: assert property (p_up_cal) else $error("supply step too short");
  property p_dn_cal; down_step_pulse |=> cal_sink_en [*2]; endproperty
  a_dn_cal: assert property (p_dn_cal) else $error("sink step too short");
  // first edge after release holds discharge, so skip it
  property p_phase; $past(reset_n) |=> charge_ctrl != $past(charge_ctrl); endproperty
  a_phase: assert property (p_phase) else $error("charge phase stuck");
  property p_rate; (up_step_pulse || down_step_pulse) |=> !(up_step_pulse || down_step_pulse);
  endproperty
  a_rate: assert property (p_rate) else $error("steps closer than two cycles");
  property p_oc; overcurrent [*2] |=> !switch_output; endproperty
  a_oc: assert property (p_oc) else $error("output on under overcurrent");
  property p_oe; switch_output_oe_n == !switch_output; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_push;
    output_mode_select == 2'h0 && $past(output_mode_select) == 2'h0 && !overcurrent
      && !$past(overcurrent) |-> switch_output == capacitive_event;
  endproperty
  a_push: assert property (p_push) else $error("push output not following event");
  property p_change;
    (up_step_pulse ##[2:4] down_step_pulse) or (down_step_pulse ##[2:4] up_step_pulse)
      |-> ##2 !capacitive_event;
  endproperty
  a_change: assert property (p_change) else $error("event kept after turn");
  property p_rise;
    $rose(capacitive_event) |-> $past(up_step_pulse, 2) || $past(down_step_pulse, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("event without a step");
endmodule
bind touch_decision touch_decision_sva u_sva (
  .clk(clk), .reset_n(reset_n), .output_mode_select(output_mode_select),
  .overcurrent(overcurrent), .charge_ctrl(charge_ctrl), .up_step_pulse(up_step_pulse),
  .down_step_pulse(down_step_pulse), .cal_supply_en(cal_supply_en),
  .cal_sink_en(cal_sink_en), .capacitive_event(capacitive_event),
  .switch_output(switch_output), .switch_output_oe_n(switch_output_oe_n)
);
